// ===== rtl/lcdpi_pkg.sv
/*
  lcdpi_pkg: register map, field positions, reset values, timing counts,
  the controller state type and the panel output bundle of the lcd panel
  timing block.
  Assumes pclk runs at 200 MHz and software reaches the block over apb.
*/
// How it works
// - marker spans first line pulse to next
// - marker polarity chosen by software
// - line pulse after line, 8 pixel clocks
// - line pulse polarity chosen by software
// - data follows shift clock, polarity selectable
// - crystal direction toggles every 1..16 frames
// - one, two or four bit data bus
// - optional inversion of all data bits
// - pixel zero of line on bit 0
// - dma transfer lasts 1..16 dma clocks
// - dma runs from the screen dma clock
// - controller off stops before next fill
// - burst field bits 5:2 plus one
// - up to 1024 rows, 512 columns
// - address strobe idle during display dma
package lcdpi_pkg;

  // register byte offsets
  localparam logic [11:0] LCDPI_OFS_CTRL = 12'h000;
  localparam logic [11:0] LCDPI_OFS_CLKC = 12'h004;
  localparam logic [11:0] LCDPI_OFS_SIZE = 12'h008;
  localparam logic [11:0] LCDPI_OFS_BASE = 12'h00c;
  localparam logic [11:0] LCDPI_OFS_STAT = 12'h010;

  // control register fields
  localparam int CTRL_FLM_POL = 0;
  localparam int CTRL_LP_POL  = 1;
  localparam int CTRL_SCK_POL = 2;
  localparam int CTRL_INV     = 3;
  localparam int CTRL_WID     = 4;
  localparam int CTRL_ACD     = 8;

  // display clocking control fields
  localparam int CLKC_WS = 2;
  localparam int CLKC_ON = 7;

  // size register fields (columns minus one, rows minus one)
  localparam int SIZE_COL = 0;
  localparam int SIZE_ROW = 16;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [7:0]  CLKC_RST = 8'h40;
  localparam logic [31:0] SIZE_RST = 32'h00ef009f;
  localparam logic [23:0] BASE_RST = 24'h000000;

  // panel data width codes
  localparam logic [1:0] WID_1 = 2'h0;
  localparam logic [1:0] WID_2 = 2'h1;
  localparam logic [1:0] WID_4 = 2'h2;

  // timing
  localparam int LP_PIX   = 8;
  localparam int PCLK_NS  = 5;
  localparam int PIX_NS   = 40;
  localparam int PIX_CYC  = (PIX_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int MAX_COLS = 512;
  localparam int MAX_ROWS = 1024;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FILL  = 2'h1,
    ST_SHIFT = 2'h3,
    ST_LATCH = 2'h2
  } lcdpi_state_t;

  typedef struct packed {
    logic       first_line_marker;
    logic       line_latch_pulse;
    logic       shift_clock_out;
    logic       crystal_direction_toggle;
    logic [3:0] panel_data_bus;
  } lcdpi_panel_t;

endpackage

// ===== rtl/lcdpi_sync.sv
/*
  lcdpi_sync: two flip-flop synchroniser with a rising edge pulse.
  Assumes async_in is a slow level from another clock domain.
*/
`timescale 1ns/100ps
module lcdpi_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // foreign level and its edge
  input  wire logic async_in,
  output logic      rise
);

  logic meta;
  logic sync;
  logic sync_d;

  // only the second stage and its delayed copy are ever looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      meta   <= async_in;
      sync   <= meta;
      sync_d <= sync;
    end
  end

  assign rise = sync & ~sync_d;

endmodule // lcdpi_sync

// ===== rtl/lcdpi_top.sv
/*
  lcdpi_top: lcd panel timing controller. Fetches each line into a line
  buffer by dma bursts timed on the screen dma clock, then shifts it out
  with shift clock, line pulse, first line marker and crystal direction.
  Assumes memory holds dma_rdata valid while dma_req is high and dma_addr
  is stable, and that screen_dma_clock is much slower than pclk.
*/
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module lcdpi_top
  import lcdpi_pkg::*;
#(
  parameter int PIX_DIV  = PIX_CYC,
  parameter int MAX_C    = MAX_COLS,
  parameter int MAX_R    = MAX_ROWS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // screen dma
  input  wire logic        screen_dma_clock,
  output logic             dma_req,
  output logic      [23:0] dma_addr,
  input  wire logic [15:0] dma_rdata,
  input  wire logic        core_strobe_n,
  output logic             address_valid_strobe_n,
  // panel
  output lcdpi_panel_t     panel
);

  // refuse settings the counters cannot hold
  generate
    if (PIX_DIV < 2 || PIX_DIV > 256 || PIX_DIV % 2 != 0) begin : g_bad_div
      $error("pixel divider must be even, 2 to 256");
    end
    if (MAX_C > 512 || MAX_C % 16 != 0 || MAX_R > 1024) begin : g_bad_size
      $error("panel size beyond counter range");
    end
  endgenerate

  localparam int         WORDS    = MAX_C / 16;
  localparam logic [7:0] PIX_LAST = 8'(PIX_DIV - 1);
  localparam logic [7:0] PIX_HALF = 8'(PIX_DIV / 2);
  localparam logic [3:0] LP_LAST  = 4'(LP_PIX - 1);
  localparam logic [11:0] LP_TOT  = 12'(LP_PIX * PIX_DIV);

  // register index, 7 for an unmapped address
  function automatic logic [2:0] reg_idx(input logic [11:0] a);
    case (a)
      LCDPI_OFS_CTRL: reg_idx = 3'h0;
      LCDPI_OFS_CLKC: reg_idx = 3'h1;
      LCDPI_OFS_SIZE: reg_idx = 3'h2;
      LCDPI_OFS_BASE: reg_idx = 3'h3;
      LCDPI_OFS_STAT: reg_idx = 3'h4;
      default:        reg_idx = 3'h7;
    endcase
  endfunction

  // pixels advanced per shift clock
  function automatic logic [2:0] step_of(input logic [1:0] w);
    case (w)
      WID_1:   step_of = 3'h1;
      WID_2:   step_of = 3'h2;
      default: step_of = 3'h4;
    endcase
  endfunction

  // pixel col lands on bit 0, the following ones on higher bits
  function automatic logic [3:0] pick(input logic [15:0] w, input logic [3:0] off,
                                      input logic [1:0] wid);
    logic [15:0] s;
    s = w >> off;
    case (wid)
      WID_1:   pick = {3'h0, s[0]};
      WID_2:   pick = {2'h0, s[1:0]};
      default: pick = s[3:0];
    endcase
  endfunction

  logic [31:0]  ctrl;
  logic [7:0]   clkc;
  logic [31:0]  size;
  logic [23:0]  base;
  logic [31:0]  rd_word;
  logic         acc;
  logic         on;
  logic [3:0]   burst;
  logic [8:0]   cols_m1;
  logic [9:0]   rows_m1;
  logic [4:0]   words_m1;
  logic [1:0]   wid;
  logic [3:0]   acd_per;
  lcdpi_state_t state;
  logic [4:0]   word;
  logic [3:0]   bcnt;
  logic [8:0]   col;
  logic [7:0]   pix;
  logic [3:0]   lpc;
  logic [9:0]   row;
  logic [23:0]  addr;
  logic         dma_edge;
  logic         word_cap;
  logic         pix_tick;
  logic         line_end;
  logic         lp_start;
  logic         lp_end;
  logic         sck_act;
  logic [3:0]   cur_data;
  logic         flm_act;
  logic         acd;
  logic [3:0]   acd_cnt;
  logic [15:0]  line_buf [0:WORDS-1];
  logic [11:0]  lp_len;

  assign acc      = psel & penable & ~pready;
  assign on       = clkc[CLKC_ON];
  assign burst    = clkc[CLKC_WS +: 4];
  assign cols_m1  = size[SIZE_COL +: 9];
  assign rows_m1  = size[SIZE_ROW +: 10];
  assign words_m1 = cols_m1[8:4];
  assign wid      = ctrl[CTRL_WID +: 2];
  assign acd_per  = ctrl[CTRL_ACD +: 4];

  // screen dma clock is sampled, its rising edges pace each burst
  lcdpi_sync u_dma_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (screen_dma_clock),
    .rise     (dma_edge)
  );

  // software writes; reserved bits are not stored so they read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      clkc <= CLKC_RST;
      size <= SIZE_RST;
      base <= BASE_RST;
    end else if (acc && pwrite) begin
      case (reg_idx(paddr))
        3'h0:    ctrl <= {20'h00000, pwdata[11:8], 2'h0, pwdata[5:0]};
        3'h1:    clkc <= {pwdata[7:2], 2'h0};
        3'h2:    size <= {6'h00, pwdata[25:16], 7'h00, pwdata[8:0]};
        3'h3:    base <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // read data selection
  always_comb begin
    case (reg_idx(paddr))
      3'h0:    rd_word = ctrl;
      3'h1:    rd_word = {24'h000000, clkc};
      3'h2:    rd_word = size;
      3'h3:    rd_word = {8'h00, base};
      3'h4:    rd_word = {6'h00, row, 12'h000, acd, flm_act, state};
      default: rd_word = 32'h00000000;
    endcase
  end

  // one wait state so every apb output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc && reg_idx(paddr) == 3'h7;
      prdata  <= (acc && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  assign word_cap = state == ST_FILL && dma_req && dma_edge && bcnt == burst;
  assign pix_tick = pix == PIX_LAST;
  assign line_end = ({1'b0, col} + {7'h00, step_of(wid)}) > {1'b0, cols_m1};
  assign lp_start = state == ST_SHIFT && pix_tick && line_end;
  assign lp_end   = state == ST_LATCH && pix_tick && lpc == LP_LAST;

  // sequencer: fill the line buffer, shift it out, then latch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      word  <= 5'h00;
      bcnt  <= 4'h0;
      col   <= 9'h000;
      pix   <= 8'h00;
      lpc   <= 4'h0;
      row   <= 10'h000;
      addr  <= 24'h000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (row == 10'h000) begin
            addr <= base;
          end
          if (on) begin
            state <= ST_FILL;
            word  <= 5'h00;
            bcnt  <= 4'h0;
          end
        end
        ST_FILL: begin
          if (word_cap) begin
            bcnt <= 4'h0;
            addr <= addr + 24'h000001;
            if (word == words_m1) begin
              state <= ST_SHIFT;
              col   <= 9'h000;
              pix   <= 8'h00;
            end else begin
              word <= word + 5'h01;
            end
          end else if (dma_edge && dma_req) begin
            bcnt <= bcnt + 4'h1;
          end
        end
        ST_SHIFT: begin
          pix <= pix_tick ? 8'h00 : pix + 8'h01;
          if (pix_tick) begin
            if (line_end) begin
              state <= ST_LATCH;
              lpc   <= 4'h0;
            end else begin
              col <= col + {6'h00, step_of(wid)};
            end
          end
        end
        ST_LATCH: begin
          pix <= pix_tick ? 8'h00 : pix + 8'h01;
          if (lp_end) begin
            word <= 5'h00;
            if (row == rows_m1) begin
              row  <= 10'h000;
              addr <= base;
            end else begin
              row <= row + 10'h001;
            end
            // switching off only takes effect between lines
            state <= on ? ST_FILL : ST_IDLE;
          end else if (pix_tick) begin
            lpc <= lpc + 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // line buffer; no reset, every word is written before it is shifted
  always_ff @(posedge pclk) begin
    if (word_cap && int'(word) < WORDS) begin
      line_buf[word] <= dma_rdata;
    end
  end

  // first line marker and crystal direction, frames counted on the marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flm_act <= 1'b0;
      acd     <= 1'b0;
      acd_cnt <= 4'h0;
    end else if (lp_start) begin
      flm_act <= 1'b0;
    end else if (lp_end && row == 10'h000) begin
      flm_act <= 1'b1;
      if (acd_cnt == acd_per) begin
        acd     <= ~acd;
        acd_cnt <= 4'h0;
      end else begin
        acd_cnt <= acd_cnt + 4'h1;
      end
    end
  end

  // shift clock high in the second half of each pixel period
  assign sck_act  = state == ST_SHIFT && pix >= PIX_HALF;
  assign cur_data = pick(line_buf[col[8:4]], col[3:0], wid);

  // registered pin drivers with software polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel                  <= '0;
      dma_req                <= 1'b0;
      dma_addr               <= 24'h000000;
      address_valid_strobe_n <= 1'b1;
    end else begin
      panel.first_line_marker        <= flm_act ^ ctrl[CTRL_FLM_POL];
      panel.line_latch_pulse         <= (state == ST_LATCH) ^ ctrl[CTRL_LP_POL];
      panel.shift_clock_out          <= sck_act ^ ctrl[CTRL_SCK_POL];
      panel.crystal_direction_toggle <= acd;
      panel.panel_data_bus           <= (state == ST_SHIFT ? cur_data : 4'h0)
                                        ^ {4{ctrl[CTRL_INV]}};
      dma_req                        <= state == ST_FILL && !word_cap;
      dma_addr                       <= addr;
      // the core's strobe is held off for the whole fill
      address_valid_strobe_n         <= (state == ST_FILL) | core_strobe_n;
    end
  end

  // cycles spent in the line pulse, read only by the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_len <= 12'h000;
    end else begin
      lp_len <= (state == ST_LATCH) ? lp_len + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flm_rise_a: assert property (
    $rose(flm_act) |-> $past(state) == ST_LATCH && $past(row) == 10'h000)
    else $error("marker rose outside first line pulse");

  flm_fall_a: assert property (
    $fell(flm_act) |-> state == ST_LATCH && $past(state) == ST_SHIFT)
    else $error("marker not cleared at next line pulse");

  flm_pol_a: assert property (
    $past(flm_act) && $past(ctrl[CTRL_FLM_POL])
    |-> !panel.first_line_marker)
    else $error("active low marker not low");

  lp_width_a: assert property (
    $past(state) == ST_LATCH && state != ST_LATCH |-> lp_len == LP_TOT)
    else $error("line pulse length wrong");

  lp_pol_a: assert property (
    state == ST_LATCH |=> panel.line_latch_pulse == !$past(ctrl[CTRL_LP_POL]))
    else $error("line pulse level wrong");

  sck_idle_a: assert property (
    state != ST_SHIFT |=> panel.shift_clock_out == $past(ctrl[CTRL_SCK_POL]))
    else $error("shift clock not idle outside shifting");

  acd_step_a: assert property (
    $changed(acd) |-> $rose(flm_act))
    else $error("crystal direction changed off frame start");

  burst_len_a: assert property (
    state == ST_FILL && dma_req && dma_edge && bcnt != burst
    |=> bcnt == $past(bcnt) + 4'h1 && word == $past(word))
    else $error("burst ended early");

  strobe_dma_a: assert property (
    dma_req |-> address_valid_strobe_n)
    else $error("address strobe during display dma");

  off_hold_a: assert property (
    state == ST_IDLE && !on |=> state == ST_IDLE ##1 !sck_act)
    else $error("controller ran while off");

  data_map_a: assert property (
    state == ST_SHIFT && wid == WID_1
    |=> panel.panel_data_bus[3:1] == {3{$past(ctrl[CTRL_INV])}})
    else $error("unused data bits not at idle level");

  frame_c:  cover property ($rose(flm_act));
  off_c:    cover property (state == ST_LATCH ##1 state == ST_IDLE);
  burst16_c: cover property (word_cap && burst == 4'hf);
  acd_c:    cover property ($changed(acd));

endmodule // lcdpi_top

// ===== test/lcdpi_panel_model.sv
/*
  lcdpi_panel_model: passive panel that samples data groups on the active
  shift clock edge and latches a line when the line pulse ends.
  Assumes pol matches the polarity bits written into the block.
*/
`timescale 1ns/100ps
module lcdpi_panel_model
  import lcdpi_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // panel pins and the polarity they use
  input  wire lcdpi_panel_t  panel,
  input  wire logic          pol,
  // last latched line
  output logic        [63:0] line_cap,
  output int                 groups,
  output int                 lp_len,
  output int                 lines,
  output int                 frames,
  output int                 toggles,
  output logic               flm_line
);
  logic        sck, lp, flm, sck_q, lp_q, flm_q, acd_q, flm_first;
  logic [63:0] cap;
  int          g, lp_cnt;

  // fold polarity so edges below are active edges
  assign sck = panel.shift_clock_out ^ pol;
  assign lp  = panel.line_latch_pulse ^ pol;
  assign flm = panel.first_line_marker ^ pol;

  // newest group lands in the top nibble, like a column driver chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sck_q, lp_q, flm_q, acd_q, flm_first, flm_line} <= '0;
      {cap, line_cap} <= '0;
      {g, groups, lp_cnt, lp_len, lines, frames, toggles} <= '0;
    end else begin
      sck_q <= sck;
      lp_q  <= lp;
      flm_q <= flm;
      acd_q <= panel.crystal_direction_toggle;
      if (sck && !sck_q) begin
        cap <= {panel.panel_data_bus, cap[63:4]};
        g   <= g + 1;
        if (g == 0) flm_first <= flm;
      end
      if (lp) lp_cnt <= lp_cnt + 1;
      if (!lp && lp_q) begin
        line_cap <= cap;
        groups   <= g;
        lp_len   <= lp_cnt;
        lp_cnt   <= 0;
        g        <= 0;
        flm_line <= flm_first;
        lines    <= lines + 1;
      end
      if (flm && !flm_q) frames <= frames + 1;
      if (panel.crystal_direction_toggle != acd_q) toggles <= toggles + 1;
    end
  end
endmodule // lcdpi_panel_model

// ===== test/tb.sv
/*
  tb: register, frame, width, burst and on/off tests of the panel block.
  Assumes memory answers word a with {~a[7:0], a[7:0]}.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s expected %h got %h", nm, ex, got); end end
module tb;
  import lcdpi_pkg::*;
  localparam int PD = 4;
  logic         pclk, presetn, psel, penable, pwrite, sdc, cs_n, as_n;
  logic         pready, pslverr, dma_req, pol, flm_line, e, inv;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q;
  logic [23:0]  dma_addr;
  logic [15:0]  dma_rdata;
  logic [63:0]  line_cap;
  logic [1:0]   wid;
  lcdpi_panel_t panel;
  int           groups, lp_len, lines, frames, toggles, l, l0, f0, t0;
  int           err_count, n_compared, fill_len, fill_cnt, bad_as, i;

  lcdpi_top #(.PIX_DIV(PD)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .screen_dma_clock(sdc), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_rdata(dma_rdata), .core_strobe_n(cs_n),
    .address_valid_strobe_n(as_n), .panel(panel));
  lcdpi_panel_model pm (.pclk(pclk), .presetn(presetn), .panel(panel), .pol(pol),
    .line_cap(line_cap), .groups(groups), .lp_len(lp_len), .lines(lines),
    .frames(frames), .toggles(toggles), .flm_line(flm_line));

  // clocks, dma clock unrelated in phase
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    sdc = 0;
    #37;
    forever #80 sdc = ~sdc;
  end

  // memory answers at once during fill, else scrambles; a registered answer
  // would miss a word taken at the first dma clock edge of a short burst
  assign dma_rdata = dma_req ? {~dma_addr[7:0], dma_addr[7:0]}
                             : {dma_addr[7:0], ~dma_addr[7:0]};
  // fill length and strobe watch
  always @(posedge pclk) begin
    fill_cnt  <= dma_req ? fill_cnt + 1 : 0;
    if (!dma_req && fill_cnt != 0) fill_len <= fill_cnt;
    if (dma_req && !as_n) bad_as <= bad_as + 1;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      err_count++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input logic ee);
    apb(0, a, 32'h00000000);
    `CHK("prdata", ex, q)
    `CHK("pslverr", ee, e)
  endtask

  task automatic wait_line();
    int k;
    l = lines;
    for (k = 0; k < 5000; k++) begin
      @(posedge pclk);
      if (lines != l) break;
    end
    if (k == 5000) begin
      err_count++;
      results();
    end
  endtask

  // expected groups from the row's memory word, width and inversion
  task automatic chk_line(input logic [1:0] w, input logic iv);
    logic [63:0] ex, mk;
    logic [15:0] wd;
    logic [7:0]  a;
    int          pw, ng, k, b, row, bs;
    wait_line();
    row = (lines - l0 - 1) % 2;
    a   = 8'h10 + 8'(row);
    wd  = {~a, a};
    pw  = (w == WID_1) ? 1 : (w == WID_2) ? 2 : 4;
    ng  = 16 / pw;
    bs  = 64 - 4 * ng;
    ex  = '0;
    mk  = '0;
    for (k = 0; k < ng; k++) for (b = 0; b < 4; b++) begin
      mk[bs + 4 * k + b] = 1'b1;
      ex[bs + 4 * k + b] = iv ^ ((b < pw) ? wd[k * pw + b] : 1'b0);
    end
    `CHK("line data", ex, line_cap & mk)
    `CHK("groups", ng, groups)
    `CHK("lp len", 8 * PD, lp_len)
    `CHK("marker", row == 1, flm_line)
    if (row == 1) `CHK("crystal", (frames - f0) / 2, toggles - t0)
  endtask

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, cs_n, pol} = '0;
    {paddr, pwdata} = '0;
    {err_count, n_compared, fill_cnt, fill_len, bad_as} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd_chk(LCDPI_OFS_CTRL, CTRL_RST, 0);
    rd_chk(LCDPI_OFS_CLKC, {24'h000000, CLKC_RST}, 0);
    rd_chk(LCDPI_OFS_SIZE, SIZE_RST, 0);
    rd_chk(LCDPI_OFS_BASE, {8'h00, BASE_RST}, 0);
    apb(1, LCDPI_OFS_SIZE, 32'hffffffff);
    rd_chk(LCDPI_OFS_SIZE, 32'h03ff01ff, 0);
    apb(1, 12'h020, 32'hffffffff);
    `CHK("write err", 1'b1, e)
    rd_chk(12'h020, 32'h00000000, 1);
    apb(1, LCDPI_OFS_STAT, 32'hffffffff);
    rd_chk(LCDPI_OFS_STAT, 32'h00000000, 0);
    `CHK("idle high pol", 8'h00, panel)
    $display("test registers done");
    // active-low pins, crystal every 2 frames, 16 columns by 2 rows
    apb(1, LCDPI_OFS_SIZE, 32'h0001000f);
    apb(1, LCDPI_OFS_BASE, 32'h00000010);
    apb(1, LCDPI_OFS_CTRL, 32'h00000107);
    pol <= 1;
    repeat (20) @(posedge pclk);
    `CHK("idle low pol", 8'he0, panel)
    `CHK("strobe idle", 1'b0, as_n)
    cs_n <= 1;
    repeat (2) @(posedge pclk);
    `CHK("strobe follows", 1'b1, as_n)
    cs_n <= 0;
    l0 = lines;
    f0 = frames;
    t0 = toggles;
    apb(1, LCDPI_OFS_CLKC, 32'h000000c0);
    repeat (4) chk_line(WID_1, 0);
    `CHK("fill short", 1'b1, fill_len > 0 && fill_len <= 40)
    $display("test frame done");
    for (i = 0; i < 3; i++) begin
      wid = (i == 0) ? WID_2 : (i == 1) ? WID_4 : WID_1;
      inv = (i != 1);
      apb(1, LCDPI_OFS_CTRL, {20'h00000, 4'h1, 2'h0, wid, inv, 3'h7});
      wait_line();
      repeat (2) chk_line(wid, inv);
    end
    $display("test widths done");
    apb(1, LCDPI_OFS_CLKC, 32'h000000fc);
    wait_line();
    chk_line(WID_1, 1);
    `CHK("fill long", 1'b1, fill_len > 480 && fill_len <= 520)
    $display("test burst done");
    // off lets the line finish, then nothing moves
    apb(1, LCDPI_OFS_CLKC, 32'h00000040);
    wait_line();
    l = lines;
    repeat (800) @(posedge pclk);
    `CHK("lines off", l, lines)
    `CHK("dma off", 1'b0, dma_req)
    apb(1, LCDPI_OFS_CLKC, 32'h000000c0);
    repeat (2) chk_line(WID_1, 1);
    `CHK("strobe in fill", 0, bad_as)
    $display("test on off done");
    results();
  end
endmodule // tb
